// ===== logic/async_dram_pkg.sv
/*
  Shared constants and types for the asynchronous memory bus bridge:
  bus widths, address field positions, divider and timing counts.
  Assumes both ends run on the same 40 MHz system clock CLK.
*/
package async_dram_pkg;

  // bus shape
  localparam int ADDR_W     = 21;
  localparam int DATA_W     = 16;
  localparam int BLOCKS     = 4;
  localparam int ACK_STAGES = 8;

  // address field positions (true polarity, after inversion)
  localparam int POS_MSB  = 20;
  localparam int POS_LSB  = 19;
  localparam int BLK_MSB  = 18;
  localparam int BLK_LSB  = 17;
  localparam int ROW_LSB  = 0;
  localparam int COL_LSB  = 8;
  localparam int BANK_BIT = 16;

  // system clock
  localparam int SYS_CLK_MHZ   = 40;
  localparam int CLK_PERIOD_NS = 25;

  // controller clock must stay below this rate
  localparam int CTRL_CLK_MAX_MHZ = 10;
  localparam int CTRL_DIV_HALF =
    (SYS_CLK_MHZ / CTRL_CLK_MAX_MHZ) / 2 + 1;

  // bus clock made by the master, at or below its nominal rate
  localparam int BUS_CLK_MHZ  = 8;
  localparam int BUS_DIV_HALF =
    (SYS_CLK_MHZ + 2 * BUS_CLK_MHZ - 1) / (2 * BUS_CLK_MHZ);

  // address setup ahead of a strobe, rounded up to whole cycles
  localparam int ADDR_SETUP_NS  = 25;
  localparam int ADDR_SETUP_CYC =
    (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // power-on initialisation pulse width on the bus
  localparam int INIT_HOLD_NS  = 200;
  localparam int INIT_HOLD_CYC =
    (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // jumper defaults and static controller strap values
  localparam logic [2:0] ACK_TAP_DEFAULT   = 3'h3;
  localparam logic [1:0] BOARD_POS_DEFAULT = 2'h0;
  localparam logic       FREQ_SEL_LOW_VAL  = 1'h0;
  localparam logic       FREQ_SEL_HIGH_VAL = 1'h0;
  localparam logic       WAIT_STATE_VAL    = 1'h0;
  localparam logic       REFRESH_ON_VAL    = 1'h1;

  // master sequencer
  typedef enum logic [1:0] {
    M_IDLE    = 2'b00,
    M_SETUP   = 2'b01,
    M_STROBE  = 2'b10,
    M_RELEASE = 2'b11
  } master_state_t;

endpackage : async_dram_pkg

// ===== logic/async_mem_bus_if.sv
/*
  The asynchronous memory bus between master and memory board.
  Assumes both parties drive only through their enables; the wired
  level of data and acknowledge is resolved here (released = high).
*/
interface async_mem_bus_if;
  import async_dram_pkg::*;

  logic [ADDR_W-1:0] addr_n;
  logic              memory_read_strobe_n;
  logic              memory_write_strobe_n;
  logic              system_bus_clock;
  logic              init_n;
  logic [DATA_W-1:0] m_data_out;
  logic              m_data_oe;
  logic [DATA_W-1:0] b_data_out;
  logic              b_data_oe;
  logic              b_ack_out;
  logic              b_ack_oe;
  logic [DATA_W-1:0] data_n;
  logic              ack_n;

  // wired levels; an undriven line is pulled high
  assign data_n = b_data_oe ? b_data_out
                : (m_data_oe ? m_data_out : 16'hFFFF);
  assign ack_n  = b_ack_oe ? b_ack_out : 1'b1;

  modport board (
    input  addr_n,
    input  memory_read_strobe_n,
    input  memory_write_strobe_n,
    input  system_bus_clock,
    input  init_n,
    input  data_n,
    output b_data_out,
    output b_data_oe,
    output b_ack_out,
    output b_ack_oe
  );

  modport master (
    output addr_n,
    output memory_read_strobe_n,
    output memory_write_strobe_n,
    output system_bus_clock,
    output init_n,
    output m_data_out,
    output m_data_oe,
    input  data_n,
    input  ack_n
  );

endinterface : async_mem_bus_if

// ===== logic/dram_board_end.sv
/*
  Memory board end: board and block decode, acknowledge delay chain,
  latch strobe, data buffer control and controller clock.
  Assumes a bus master on the bus side and up to four DRAM controllers
  with their RAM on the user side; every pin is foreign to CLK.
*/
// Contract
// RQ1 - acknowledge only once read data is valid
// RQ2 - 21 address, 16 data, read/write strobes
// RQ3 - top bits place board in one of four
// RQ4 - delay chain cleared idle, fills per clock
// RQ5 - acknowledge stage chosen by jumper setting
// RQ6 - stage chosen for worst-case start phase
// RQ7 - same chain makes the latch strobe
// RQ8 - controller ready gates the chain clock
// RQ9 - buffers enabled by select, direction by read
// RQ10 - four active-low block selects, 128K each
// RQ11 - block ready gates its own acknowledge
// RQ12 - controllers share strobe, request, address lines
// RQ13 - latch strobe admitted on rising controller clock
// RQ14 - controller clock divided below 10 MHz
// RQ15 - divided synchroniser delay stays bounded
// RQ16 - initialisation clears chain, drops acknowledge
module dram_board_end
  import async_dram_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // bus side
  async_mem_bus_if.board         bus,
  // jumpers
  input  wire logic [1:0]        BOARD_POSITION,
  input  wire logic [2:0]        ACK_TAP,
  // controller side
  input  wire logic [BLOCKS-1:0] BLOCK_READY,
  output logic [BLOCKS-1:0]      BLOCK_SELECT_N,
  output logic                   LATCH_STROBE,
  output logic                   ACCESS_READ_REQUEST_N,
  output logic                   ACCESS_WRITE_REQUEST_N,
  output logic                   REFRESH_ENABLE_ONE,
  output logic                   CONTROLLER_CLOCK,
  output logic [7:0]             ROW_ADDRESS,
  output logic [7:0]             COLUMN_ADDRESS,
  output logic                   BANK_SELECT,
  output logic                   FREQUENCY_SELECT_LOW,
  output logic                   FREQUENCY_SELECT_HIGH,
  output logic                   WAIT_STATE_SELECT,
  // ram data side
  input  wire logic [DATA_W-1:0] DRAM_DATA_IN,
  output logic [DATA_W-1:0]      DRAM_DATA_OUT,
  output logic                   DRAM_DATA_OE
);

  localparam int SYNC_W = ADDR_W + 4 + DATA_W + BLOCKS + 2 + 3 + DATA_W;

  // low-active select for one block
  function automatic logic [BLOCKS-1:0] block_onehot_n(
    input logic [1:0] blk
  );
    block_onehot_n = ~(4'h1 << blk);
  endfunction : block_onehot_n

  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [ADDR_W-1:0] addr_s;
  logic              rd_n_s, wr_n_s, bclk_s, init_n_s;
  logic [DATA_W-1:0] bus_data_s, ram_data_s;
  logic [BLOCKS-1:0] ready_s;
  logic [1:0]        pos_s;
  logic [2:0]        tap_s;

  // two-stage synchroniser for every foreign input
  always_ff @(posedge CLK) begin
    sync1_q <= {bus.addr_n, bus.memory_read_strobe_n,
                bus.memory_write_strobe_n, bus.system_bus_clock,
                bus.init_n, bus.data_n, BLOCK_READY, BOARD_POSITION,
                ACK_TAP, DRAM_DATA_IN};
    sync2_q <= sync1_q;
  end

  assign {addr_s, rd_n_s, wr_n_s, bclk_s, init_n_s, bus_data_s,
          ready_s, pos_s, tap_s, ram_data_s} = sync2_q;

  // decode; bus lines are low-active, so invert once here
  logic [ADDR_W-1:0] addr;
  logic              rd, wr, board_sel, ready_sel, rst;
  logic [1:0]        blk;
  assign addr      = ~addr_s; // RQ2
  assign rd        = ~rd_n_s;
  assign wr        = ~wr_n_s;
  assign blk       = addr[BLK_MSB:BLK_LSB];
  assign board_sel = (rd | wr) && (addr[POS_MSB:POS_LSB] == pos_s); // RQ3
  assign ready_sel = ready_s[blk]; // RQ11
  assign rst       = SYS_RST | ~init_n_s; // RQ16

  // acknowledge delay chain
  logic [ACK_STAGES-1:0] chain_q, chain_d;
  logic                  bclk_prev_q, bclk_prev_d;
  logic                  ack_q, ack_d;
  logic                  latch_q, latch_d;
  always_comb begin
    bclk_prev_d = bclk_s;
    chain_d     = chain_q;
    if (!board_sel) begin
      chain_d = '0; // RQ4
    end else if (bclk_s && !bclk_prev_q && ready_sel
                 && (latch_q || chain_q[0])) begin
      // refresh holds ready low, freezing the chain; nothing shifts
      // before the latch strobe is out, so no ack can precede it
      chain_d = {chain_q[ACK_STAGES-2:0], 1'b1}; // RQ4 RQ8
    end
    // the tap must cover access time even if the board woke just
    // before a shift edge, so count one period as lost
    ack_d = board_sel && chain_q[tap_s] && ready_sel; // RQ1 RQ5 RQ6 RQ11
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      chain_q     <= '0; // RQ16
      bclk_prev_q <= 1'b0;
      ack_q       <= 1'b0; // RQ16
    end else begin
      chain_q     <= chain_d;
      bclk_prev_q <= bclk_prev_d;
      ack_q       <= ack_d;
    end
  end

  // controller clock divider and gated latch strobe
  logic [2:0] div_q, div_d;
  logic       cclk_q, cclk_d, ctrl_rise;
  always_comb begin
    ctrl_rise = (div_q == 3'(CTRL_DIV_HALF - 1)) && !cclk_q;
    div_d     = (div_q == 3'(CTRL_DIV_HALF - 1)) ? 3'h0 : div_q + 3'h1;
    cclk_d    = (div_q == 3'(CTRL_DIV_HALF - 1)) ? ~cclk_q : cclk_q; // RQ14
    // strobe stands from select until the chain's second stage fills;
    // the chain waits for the strobe, so every access gets exactly one;
    // admitting it only at a rising clock costs up to one period
    latch_d   = ctrl_rise ? (board_sel && !chain_q[1])
                          : latch_q; // RQ7 RQ13 RQ15
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      div_q   <= '0;
      cclk_q  <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      div_q   <= div_d;
      cclk_q  <= cclk_d;
      latch_q <= latch_d;
    end
  end

  // shared controller lines, selects and data buffers
  logic [BLOCKS-1:0] bsel_n_q, bsel_n_d;
  logic              acr_n_q, acr_n_d, acw_n_q, acw_n_d;
  logic [7:0]        row_q, row_d, col_q, col_d;
  logic              bank_q, bank_d;
  logic [DATA_W-1:0] bus_out_q, bus_out_d, ram_out_q, ram_out_d;
  logic              bus_oe_q, bus_oe_d, ram_oe_q, ram_oe_d;
  always_comb begin
    bsel_n_d  = board_sel ? block_onehot_n(blk) : 4'hF; // RQ10
    acr_n_d   = ~(board_sel && rd); // RQ12
    acw_n_d   = ~(board_sel && wr); // RQ12
    row_d     = addr[ROW_LSB +: 8]; // RQ12
    col_d     = addr[COL_LSB +: 8];
    bank_d    = addr[BANK_BIT];
    bus_oe_d  = board_sel && rd; // RQ9
    bus_out_d = ~ram_data_s; // bus data is low-active
    ram_oe_d  = board_sel && wr; // RQ9
    ram_out_d = ~bus_data_s;
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      bsel_n_q  <= 4'hF;
      acr_n_q   <= 1'b1;
      acw_n_q   <= 1'b1;
      row_q     <= '0;
      col_q     <= '0;
      bank_q    <= 1'b0;
      bus_out_q <= 16'hFFFF;
      bus_oe_q  <= 1'b0;
      ram_out_q <= '0;
      ram_oe_q  <= 1'b0;
    end else begin
      bsel_n_q  <= bsel_n_d;
      acr_n_q   <= acr_n_d;
      acw_n_q   <= acw_n_d;
      row_q     <= row_d;
      col_q     <= col_d;
      bank_q    <= bank_d;
      bus_out_q <= bus_out_d;
      bus_oe_q  <= bus_oe_d;
      ram_out_q <= ram_out_d;
      ram_oe_q  <= ram_oe_d;
    end
  end

  // static strap lines, held in flops so every output but the tied-low b_ack_out is registered
  logic fs_lo_q, fs_hi_q, twait_q, refen_q;
  always_ff @(posedge CLK) begin
    fs_lo_q <= FREQ_SEL_LOW_VAL;
    fs_hi_q <= FREQ_SEL_HIGH_VAL;
    twait_q <= WAIT_STATE_VAL;
    refen_q <= REFRESH_ON_VAL;
  end

  // outputs
  assign bus.b_ack_out            = 1'b0; // open drain: only pulls low
  assign bus.b_ack_oe             = ack_q; // RQ1
  assign bus.b_data_out           = bus_out_q;
  assign bus.b_data_oe            = bus_oe_q;
  assign BLOCK_SELECT_N           = bsel_n_q;
  assign LATCH_STROBE             = latch_q;
  assign ACCESS_READ_REQUEST_N    = acr_n_q;
  assign ACCESS_WRITE_REQUEST_N   = acw_n_q;
  assign REFRESH_ENABLE_ONE       = refen_q;
  assign CONTROLLER_CLOCK         = cclk_q;
  assign ROW_ADDRESS              = row_q;
  assign COLUMN_ADDRESS           = col_q;
  assign BANK_SELECT              = bank_q;
  assign FREQUENCY_SELECT_LOW     = fs_lo_q;
  assign FREQUENCY_SELECT_HIGH    = fs_hi_q;
  assign WAIT_STATE_SELECT        = twait_q;
  assign DRAM_DATA_OUT            = ram_out_q;
  assign DRAM_DATA_OE             = ram_oe_q;

endmodule : dram_board_end

// ===== logic/bus_master_end.sv
/*
  Bus master end: makes the bus clock and the power-on initialisation
  signal and runs one read or write per user request.
  Assumes a memory board on the bus that acknowledges by pulling the
  acknowledge line low; acknowledge and data are foreign to CLK.
*/
module bus_master_end
  import async_dram_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // bus side
  async_mem_bus_if.master        bus,
  // user request
  input  wire logic              REQ_VALID,
  input  wire logic              REQ_WRITE,
  input  wire logic [ADDR_W-1:0] REQ_ADDRESS,
  input  wire logic [DATA_W-1:0] REQ_WDATA,
  output logic                   REQ_READY,
  // user answer
  output logic                   RSP_VALID,
  output logic [DATA_W-1:0]      RSP_RDATA
);

  // synchroniser for acknowledge and data
  logic [DATA_W:0] sync1_q, sync2_q;
  logic            ack_s;
  logic [DATA_W-1:0] data_s;
  always_ff @(posedge CLK) begin
    sync1_q <= {bus.ack_n, bus.data_n};
    sync2_q <= sync1_q;
  end
  assign {ack_s, data_s} = sync2_q;

  // bus clock divider and initialisation pulse
  logic [2:0] bdiv_q, bdiv_d;
  logic       bclk_q, bclk_d;
  logic [3:0] init_q, init_d;
  logic       init_n_q, init_n_d;
  always_comb begin
    bdiv_d   = (bdiv_q == 3'(BUS_DIV_HALF - 1)) ? 3'h0 : bdiv_q + 3'h1;
    bclk_d   = (bdiv_q == 3'(BUS_DIV_HALF - 1)) ? ~bclk_q : bclk_q;
    init_d   = (init_q == 4'(INIT_HOLD_CYC)) ? init_q : init_q + 4'h1;
    init_n_d = (init_q == 4'(INIT_HOLD_CYC));
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bdiv_q   <= '0;
      bclk_q   <= 1'b0;
      init_q   <= '0;
      init_n_q <= 1'b0;
    end else begin
      bdiv_q   <= bdiv_d;
      bclk_q   <= bclk_d;
      init_q   <= init_d;
      init_n_q <= init_n_d;
    end
  end

  // transfer sequencer; address settles a full cycle before a strobe
  master_state_t     st_q, st_d;
  logic [ADDR_W-1:0] addr_n_q, addr_n_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic              doe_q, doe_d, wr_q, wr_d;
  logic              rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic              rdy_q, rdy_d, rsp_q, rsp_d;
  always_comb begin
    st_d     = st_q;
    addr_n_d = addr_n_q;
    wdat_d   = wdat_q;
    rdat_d   = rdat_q;
    doe_d    = doe_q;
    wr_d     = wr_q;
    rd_n_d   = rd_n_q;
    wr_n_d   = wr_n_q;
    rsp_d    = 1'b0;
    unique case (st_q)
      M_IDLE: begin
        if (REQ_VALID && rdy_q) begin
          addr_n_d = ~REQ_ADDRESS; // RQ2
          wdat_d   = ~REQ_WDATA;
          doe_d    = REQ_WRITE;
          wr_d     = REQ_WRITE;
          st_d     = M_SETUP;
        end
      end
      M_SETUP: begin
        rd_n_d = wr_q;
        wr_n_d = ~wr_q;
        st_d   = M_STROBE;
      end
      M_STROBE: begin
        if (!ack_s) begin
          rdat_d = ~data_s;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          rsp_d  = 1'b1;
          st_d   = M_RELEASE;
        end
      end
      M_RELEASE: begin
        if (ack_s) begin
          doe_d = 1'b0;
          st_d  = M_IDLE;
        end
      end
    endcase
    rdy_d = (st_d == M_IDLE) && init_n_d;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q     <= M_IDLE;
      addr_n_q <= '1;
      wdat_q   <= 16'hFFFF;
      rdat_q   <= '0;
      doe_q    <= 1'b0;
      wr_q     <= 1'b0;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
      rdy_q    <= 1'b0;
      rsp_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      addr_n_q <= addr_n_d;
      wdat_q   <= wdat_d;
      rdat_q   <= rdat_d;
      doe_q    <= doe_d;
      wr_q     <= wr_d;
      rd_n_q   <= rd_n_d;
      wr_n_q   <= wr_n_d;
      rdy_q    <= rdy_d;
      rsp_q    <= rsp_d;
    end
  end

  // outputs
  assign bus.addr_n                = addr_n_q;
  assign bus.memory_read_strobe_n  = rd_n_q;
  assign bus.memory_write_strobe_n = wr_n_q;
  assign bus.system_bus_clock      = bclk_q;
  assign bus.init_n                = init_n_q;
  assign bus.m_data_out            = wdat_q;
  assign bus.m_data_oe             = doe_q;
  assign REQ_READY                 = rdy_q;
  assign RSP_VALID                 = rsp_q;
  assign RSP_RDATA                 = rdat_q;

endmodule : bus_master_end

// ===== tb/async_bus_sva.sv
/*
  Checker for the lines between the master end and the board end.
  Assumes the bench wires it beside the bus interface, on CLK/SYS_RST.
*/
module async_bus_sva
  import async_dram_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // bus lines
  input  wire logic [ADDR_W-1:0] addr_n,
  input  wire logic              memory_read_strobe_n,
  input  wire logic              memory_write_strobe_n,
  input  wire logic              system_bus_clock,
  input  wire logic              init_n,
  input  wire logic              m_data_oe,
  input  wire logic              b_data_oe,
  input  wire logic              b_ack_oe,
  input  wire logic [DATA_W-1:0] data_n,
  input  wire logic              ack_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       busy;
  logic       bclk_q;
  logic [3:0] rises_q;
  logic [3:0] rises_d;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  // bus clock rises since the strobe fell; saturates so it cannot wrap
  assign busy = !memory_read_strobe_n || !memory_write_strobe_n;
  always_comb begin
    rises_d = rises_q;
    if (SYS_RST || !busy)
      rises_d = 4'h0;
    else if (system_bus_clock && !bclk_q && rises_q != 4'hF)
      rises_d = rises_q + 4'h1;
  end
  always_ff @(posedge CLK) begin
    bclk_q  <= system_bus_clock;
    rises_q <= rises_d;
  end

  // acknowledge and data only inside an access; one strobe at a time, address steady
  chk_ack_in_access: assert property (!ack_n |-> $past(busy, 4))
    else $error("acknowledge outside an access");
  chk_ack_read_data: assert property (
    !ack_n && !memory_read_strobe_n |-> b_data_oe)
    else $error("read acknowledged with data undriven");
  chk_data_steady: assert property (
    !ack_n && !$past(ack_n) && busy && $past(busy) |-> $stable(data_n))
    else $error("data moved while acknowledged");
  chk_board_drive: assert property (
    b_data_oe |-> memory_write_strobe_n && !m_data_oe)
    else $error("board drives data in a write");
  chk_ack_after_shift: assert property (
    $rose(b_ack_oe) |-> rises_q != 4'h0)
    else $error("acknowledge before any shift");
  chk_ack_release: assert property (!busy [*5] |-> ack_n && !b_data_oe)
    else $error("board holds the bus while idle");
  chk_init_clears: assert property (
    !init_n [*4] |-> !b_ack_oe && !b_data_oe)
    else $error("board active during initialisation");
  chk_one_strobe: assert property (
    memory_read_strobe_n || memory_write_strobe_n)
    else $error("both strobes low");
  chk_addr_steady: assert property (
    busy && $past(busy) |-> $stable(addr_n))
    else $error("address moved inside an access");

  // main scenarios
  cov_read: cover property (!ack_n && !memory_read_strobe_n);
  cov_write: cover property (!ack_n && !memory_write_strobe_n);
  cov_late: cover property ($rose(b_ack_oe) && rises_q > 4'h6);
endmodule : async_bus_sva

// ===== tb/tb.sv
/*
  Bench: master end and board end joined by the bus interface; random
  and corner accesses at the master user port, board side watched.
  Assumes the package constants and a 40 MHz clock on CLK.
*/
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb
  import async_dram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              CLK, SYS_RST, REQ_VALID, REQ_WRITE, REQ_READY;
  logic              RSP_VALID, LATCH_STROBE, CONTROLLER_CLOCK, lat_q;
  logic              ACCESS_READ_REQUEST_N, ACCESS_WRITE_REQUEST_N, ck_q;
  logic              REFRESH_ENABLE_ONE, BANK_SELECT, WAIT_STATE_SELECT;
  logic              FREQUENCY_SELECT_LOW, FREQUENCY_SELECT_HIGH;
  logic              DRAM_DATA_OE;
  logic [1:0]        BOARD_POSITION;
  logic [2:0]        ACK_TAP;
  logic [3:0]        BLOCK_READY, BLOCK_SELECT_N;
  logic [7:0]        ROW_ADDRESS, COLUMN_ADDRESS;
  logic [ADDR_W-1:0] REQ_ADDRESS;
  logic [DATA_W-1:0] REQ_WDATA, RSP_RDATA, DRAM_DATA_IN, DRAM_DATA_OUT;
  int                fail_count, n_tests, lat_rises, hi_len;
  int                seed = 66122;

  async_mem_bus_if i_async_mem_bus_if ();
  bus_master_end i_bus_master_end (.CLK, .SYS_RST,
    .bus(i_async_mem_bus_if), .REQ_VALID, .REQ_WRITE, .REQ_ADDRESS,
    .REQ_WDATA, .REQ_READY, .RSP_VALID, .RSP_RDATA);
  dram_board_end i_dram_board_end (.CLK, .SYS_RST,
    .bus(i_async_mem_bus_if), .BOARD_POSITION, .ACK_TAP, .BLOCK_READY,
    .BLOCK_SELECT_N, .LATCH_STROBE, .ACCESS_READ_REQUEST_N,
    .ACCESS_WRITE_REQUEST_N, .REFRESH_ENABLE_ONE, .CONTROLLER_CLOCK,
    .ROW_ADDRESS, .COLUMN_ADDRESS, .BANK_SELECT, .FREQUENCY_SELECT_LOW,
    .FREQUENCY_SELECT_HIGH, .WAIT_STATE_SELECT, .DRAM_DATA_IN,
    .DRAM_DATA_OUT, .DRAM_DATA_OE);
  async_bus_sva i_async_bus_sva (.CLK, .SYS_RST,
    .addr_n(i_async_mem_bus_if.addr_n),
    .memory_read_strobe_n(i_async_mem_bus_if.memory_read_strobe_n),
    .memory_write_strobe_n(i_async_mem_bus_if.memory_write_strobe_n),
    .system_bus_clock(i_async_mem_bus_if.system_bus_clock),
    .init_n(i_async_mem_bus_if.init_n),
    .m_data_oe(i_async_mem_bus_if.m_data_oe),
    .b_data_oe(i_async_mem_bus_if.b_data_oe),
    .b_ack_oe(i_async_mem_bus_if.b_ack_oe),
    .data_n(i_async_mem_bus_if.data_n), .ack_n(i_async_mem_bus_if.ack_n));

  // short handles on the wired bus levels
  wire ack_w  = i_async_mem_bus_if.ack_n;
  wire bclk_w = i_async_mem_bus_if.system_bus_clock;
  wire boe_w  = i_async_mem_bus_if.b_data_oe;
  wire busy_w = !(i_async_mem_bus_if.memory_read_strobe_n
                  && i_async_mem_bus_if.memory_write_strobe_n);

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // latch strobe moves only with a rising controller clock
  always @(negedge CLK) begin
    if (!SYS_RST) begin
      if (LATCH_STROBE !== lat_q)
        `CHK({ck_q, CONTROLLER_CLOCK}, 2'b01)
      if (LATCH_STROBE && !lat_q) lat_rises++;
      if (CONTROLLER_CLOCK) hi_len++;
      else begin
        if (ck_q) `CHK(hi_len, CTRL_DIV_HALF)
        hi_len = 0;
      end
    end else hi_len = 0;
    lat_q = LATCH_STROBE;
    ck_q  = CONTROLLER_CLOCK;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic hang_stop();
    fail_count++;
    print_verdict();
  endtask : hang_stop

  task automatic do_reset();
    SYS_RST = 1'b1;
    repeat (12) @(negedge CLK);
    `CHK({BLOCK_SELECT_N, LATCH_STROBE, ack_w, boe_w}, 7'h7A)
    SYS_RST = 1'b0;
  endtask : do_reset

  // one access at the user port; a foreign one is never answered
  task automatic do_op(input logic w, input logic [1:0] blk,
                       input logic [2:0] tap, input int stall,
                       input logic foreign);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic              bq;
    int                i, nr, nack, seen, lseen, llat;
    for (i = 0; i < 100 && REQ_READY !== 1'b1; i++) @(negedge CLK);
    if (REQ_READY !== 1'b1) hang_stop();
    BOARD_POSITION = 2'($random(seed));
    a = 21'($random(seed));
    a[20:19] = foreign ? ~BOARD_POSITION : BOARD_POSITION;
    a[18:17] = blk;
    d = 16'($random(seed));
    ACK_TAP = tap;
    DRAM_DATA_IN = 16'($random(seed));
    REQ_VALID = 1'b1;
    REQ_WRITE = w;
    REQ_ADDRESS = a;
    REQ_WDATA = d;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    lat_rises = 0;
    nr = 0;
    nack = -1;
    seen = 0;
    lseen = 400;
    llat = -1;
    bq = bclk_w;
    for (i = 0; i < (foreign ? 80 : 400) && RSP_VALID !== 1'b1; i++) begin
      @(negedge CLK);
      if (busy_w && bclk_w && !bq) nr++;
      bq = bclk_w;
      if (ack_w === 1'b0 && nack < 0) nack = nr;
      // stall: own ready low first, then only its own ready high
      BLOCK_READY = (nr < stall) ? ~(4'h1 << blk)
                  : (stall > 0) ? 4'h1 << blk : 4'hF;
      if (nr < stall) `CHK(ack_w, 1'b1)
      if (foreign) `CHK({BLOCK_SELECT_N, ack_w, boe_w}, 6'h3E)
      if (!seen && (w ? ACCESS_WRITE_REQUEST_N
                      : ACCESS_READ_REQUEST_N) === 1'b0) begin
        seen = 1;
        lseen = i;
        `CHK({ACCESS_READ_REQUEST_N, ACCESS_WRITE_REQUEST_N}, {w, !w})
        `CHK(BLOCK_SELECT_N, ~(4'h1 << blk))
        `CHK({BANK_SELECT, COLUMN_ADDRESS, ROW_ADDRESS}, a[16:0])
        `CHK({DRAM_DATA_OE, boe_w}, {w, !w})
        if (w) `CHK(DRAM_DATA_OUT, d)
      end
      if (llat < 0 && LATCH_STROBE === 1'b1) llat = i;
    end
    if (foreign) begin
      `CHK(lat_rises, 0)
      return;
    end
    if (RSP_VALID !== 1'b1) hang_stop();
    `CHK(seen, 1)
    `CHK(lat_rises, 1)
    `CHK(llat >= lseen && llat < lseen + 2 * CTRL_DIV_HALF, 1'b1)
    if (!w) `CHK(RSP_RDATA, DRAM_DATA_IN)
    if (stall == 0)
      `CHK(nack > int'(tap) && nack <= int'(tap) + 2, 1'b1)
    BLOCK_READY = 4'hF;
  endtask : do_op

  // every tap, then random taps; some accesses stalled by ready
  initial begin
    int k;
    SYS_RST = 1'b1;
    REQ_VALID = 1'b0;
    REQ_WRITE = 1'b0;
    REQ_ADDRESS = '0;
    REQ_WDATA = '0;
    BOARD_POSITION = BOARD_POS_DEFAULT;
    ACK_TAP = ACK_TAP_DEFAULT;
    BLOCK_READY = 4'hF;
    DRAM_DATA_IN = '0;
    do_reset();
    for (k = 0; k < 24; k++)
      do_op(1'($random(seed)), 2'($random(seed)),
            (k < 8) ? 3'(k) : 3'($random(seed)), (k % 6 == 5) ? 4 : 0,
            1'b0);
    `CHK({FREQUENCY_SELECT_LOW, FREQUENCY_SELECT_HIGH, WAIT_STATE_SELECT,
          REFRESH_ENABLE_ONE}, {FREQ_SEL_LOW_VAL, FREQ_SEL_HIGH_VAL,
          WAIT_STATE_VAL, REFRESH_ON_VAL})
    // the master waits forever on a foreign access, so reset mid-run
    do_op(1'b0, 2'h1, ACK_TAP_DEFAULT, 0, 1'b1);
    do_reset();
    do_op(1'b1, 2'h3, 3'h7, 3, 1'b0);
    do_op(1'b0, 2'h0, 3'h0, 0, 1'b0);
    print_verdict();
  end
endmodule : tb
